// ### src/dsp_buf2.sv
// Two-entry valid/ready buffer carrying audio words.
// Assumes both sides on clk_sys_i.
module dsp_buf2
    import dsp_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire dsp_pkg::dsp_word_type in_data_i,
    // Draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output dsp_pkg::dsp_word_type out_data_o
);
    dsp_word_type mem_reg [2];
    logic rd_ptr_reg;
    logic wr_ptr_reg;
    logic [1:0] count_reg;
    logic push;
    logic pop;

    // Handshakes; full buffer drops ready, so nothing is lost
    assign push = in_valid_i && (count_reg != 2'h2);
    assign pop = out_valid_o && out_ready_i;
    assign out_valid_o = (count_reg != 2'h0);
    assign out_data_o = mem_reg[rd_ptr_reg];

    // Storage
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            mem_reg[0] <= '0;
            mem_reg[1] <= '0;
        end
        else if (push)
        begin
            mem_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    // Pointers, fill level and a registered room flag for the filling side
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rd_ptr_reg <= 1'b0;
            wr_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
            in_ready_o <= 1'b1;
        end
        else
        begin
            in_ready_o <= !((count_reg == 2'h1 && push && !pop) || (count_reg == 2'h2 && !pop));
            if (push)
                wr_ptr_reg <= ~wr_ptr_reg;
            if (pop)
                rd_ptr_reg <= ~rd_ptr_reg;
            if (push && !pop)
                count_reg <= count_reg + 2'h1;
            else if (pop && !push)
                count_reg <= count_reg - 2'h1;
        end
    end
endmodule

// ### src/dsp_pkg.sv
// Package for the dual digital audio pin control block.
// Assumes one system clock domain; link reset arrives as a pin.
package dsp_pkg;
    // Power states of the audio function group
    typedef enum logic [1:0] {PWR_D0, PWR_D1, PWR_D2, PWR_D3} dsp_pwr_type;
    // Pin behaviour decoded from the controls
    typedef enum logic [2:0] {PIN_HIZ, PIN_ZERO, PIN_SILENT, PIN_LIVE, PIN_GPIO} dsp_pin_type;
    // Sample rate codes
    typedef enum logic [2:0] {RATE_44K1, RATE_48K, RATE_88K2, RATE_96K, RATE_176K4, RATE_192K,
        RATE_NONE} dsp_rate_type;

    // Per-converter controls
    typedef struct packed {
        logic out_enable;
        logic dig_enable;
        logic [3:0] stream_id;
        dsp_rate_type rate;
        logic [4:0] bits_per_sample;
    } dsp_cnv_ctl_type;

    // Audio word and its slot marker
    typedef struct packed {
        logic [23:0] sample;
        logic right;
    } dsp_word_type;

    localparam int SAMPLE_BITS_MAX = 24;
    localparam logic [3:0] STREAM_NONE = 4'h0;
    localparam dsp_pwr_type PWR_RESET = PWR_D3;
    localparam int CLK_HZ = 20000000;
    // Input rate recovery: clocks per subframe, and level changes per subframe
    // Change count assumes a steady payload; a changing payload skews the span
    localparam int RATE_WIN_EDGES = 46;
    localparam logic [7:0] FRAME_44K1 = 8'd226;
    localparam logic [7:0] FRAME_48K = 8'd208;
    localparam logic [7:0] FRAME_88K2 = 8'd113;
    localparam logic [7:0] FRAME_96K = 8'd104;
    localparam logic [7:0] FRAME_TOL = 8'd6;
    localparam int SYNC_STAGES = 3;
endpackage

// ### src/dsp_top.sv
// Pin control for two digital audio outputs and one digital audio input.
// Assumes reset_n_i is the link reset; controls come from the codec's
// command decoder on clk_sys_i; serial pins are asynchronous.
module dsp_top
    import dsp_pkg::*;
#(
    parameter int WORD_BITS = SAMPLE_BITS_MAX
)
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Function group power state request
    input wire logic pwr_set_i,
    input wire dsp_pkg::dsp_pwr_type pwr_value_i,
    // Converter controls
    input wire dsp_pkg::dsp_cnv_ctl_type primary_out_converter_i,
    input wire dsp_pkg::dsp_cnv_ctl_type secondary_out_converter_i,
    // Shared general I/O function of the secondary pin
    input wire logic shared_general_io_function_en_i,
    input wire logic gpio_out_i,
    input wire logic gpio_dir_out_i,
    // Playback words from the link, one stream per converter
    input wire logic pri_valid_i,
    output logic pri_ready_o,
    input wire dsp_pkg::dsp_word_type pri_data_i,
    input wire logic sec_valid_i,
    output logic sec_ready_o,
    input wire dsp_pkg::dsp_word_type sec_data_i,
    // Output pins
    output logic primary_digital_out_pin_o,
    output logic primary_digital_out_pin_oe_o,
    output logic primary_pulldown_o,
    output logic secondary_digital_out_pin_o,
    output logic secondary_digital_out_pin_oe_o,
    output logic secondary_pulldown_o,
    output logic secondary_pullup_o,
    output logic gpio_in_o,
    // Digital input pin and jack sense
    input wire logic spdif_in_pin_i,
    input wire logic in_jack_sense_i,
    input wire logic in_record_sel_i,
    input wire logic in_play_route_i,
    // Input status
    output dsp_pkg::dsp_rate_type in_rate_o,
    output logic in_jack_present_o,
    output logic in_to_record_o,
    output logic in_to_play_o,
    output logic [1:0] pwr_state_o
);
    dsp_pwr_type pwr_reg;
    dsp_pin_type pri_mode;
    dsp_pin_type sec_mode;
    logic [SYNC_STAGES-1:0] in_sync_reg;
    logic [SYNC_STAGES-1:0] gp_sync_reg;
    logic [SYNC_STAGES-1:0] jack_sync_reg;
    logic in_level_reg;
    logic [7:0] gap_cnt_reg;
    logic [7:0] span_cnt_reg;
    logic [7:0] win_cnt_reg;
    dsp_rate_type in_rate_reg;
    logic in_change;
    logic bd_valid [2];
    logic bd_ready [2];
    logic bd_room [2];
    dsp_word_type bd_data [2];
    logic [WORD_BITS-1:0] shift_reg [2];
    logic [5:0] bit_cnt_reg [2];
    logic cell_reg [2];
    logic line_reg [2];

    // Pin decode shared by both outputs
    function automatic dsp_pin_type pin_decode(input dsp_pwr_type pwr,
                                               input dsp_cnv_ctl_type ctl);
        if (pwr == PWR_D3 || !ctl.out_enable)
            pin_decode = PIN_HIZ;
        else if (pwr != PWR_D0 || !ctl.dig_enable)
            pin_decode = PIN_ZERO;
        else if (ctl.stream_id == STREAM_NONE)
            pin_decode = PIN_SILENT;
        else
            pin_decode = PIN_LIVE;
    endfunction

    // Rate binning by clocks spanned by one subframe
    function automatic dsp_rate_type rate_bin(input logic [7:0] span);
        logic [7:0] frame;
        frame = span;
        if (frame > FRAME_44K1 - FRAME_TOL && frame < FRAME_44K1 + FRAME_TOL)
            rate_bin = RATE_44K1;
        else if (frame > FRAME_48K - FRAME_TOL && frame < FRAME_48K + FRAME_TOL)
            rate_bin = RATE_48K;
        else if (frame > FRAME_88K2 - FRAME_TOL && frame < FRAME_88K2 + FRAME_TOL)
            rate_bin = RATE_88K2;
        else if (frame > FRAME_96K - FRAME_TOL && frame < FRAME_96K + FRAME_TOL)
            rate_bin = RATE_96K;
        else
            rate_bin = RATE_NONE;
    endfunction

    assign pri_mode = pin_decode(pwr_reg, primary_out_converter_i);
    assign sec_mode = shared_general_io_function_en_i ? PIN_GPIO
                      : pin_decode(pwr_reg, secondary_out_converter_i);

    // Power state; reset lands in D3
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            pwr_reg <= PWR_RESET;
        else if (pwr_set_i)
            pwr_reg <= pwr_value_i;
    end

    // Two identical output lanes, each with its own buffer and framer
    for (genvar g = 0; g < 2; g++)
    begin : lane
        dsp_pin_type mode;
        logic src_valid;
        dsp_word_type src_data;
        logic take;
        assign mode = (g == 0) ? pri_mode : sec_mode;
        assign src_valid = (g == 0) ? pri_valid_i : sec_valid_i;
        assign src_data = (g == 0) ? pri_data_i : sec_data_i;
        // Word taken at the start of each subframe; free-running per lane
        assign take = (bit_cnt_reg[g] == 6'h0) && cell_reg[g];
        dsp_buf2 u_buf (
            .clk_sys_i(clk_sys_i),
            .reset_n_i(reset_n_i),
            .in_valid_i(src_valid),
            .in_ready_o(bd_room[g]),
            .in_data_i(src_data),
            .out_valid_o(bd_valid[g]),
            .out_ready_i(bd_ready[g]),
            .out_data_o(bd_data[g])
        );
        assign bd_ready[g] = take && (mode == PIN_LIVE) && (pwr_reg == PWR_D0);
        // Biphase framer: each bit is two cells, a transition every bit
        always_ff @(posedge clk_sys_i or negedge reset_n_i)
        begin
            if (!reset_n_i)
            begin
                shift_reg[g] <= '0;
                bit_cnt_reg[g] <= 6'h0;
                cell_reg[g] <= 1'b0;
                line_reg[g] <= 1'b0;
            end
            else if (mode == PIN_SILENT || mode == PIN_LIVE)
            begin
                cell_reg[g] <= ~cell_reg[g];
                if (cell_reg[g])
                begin
                    line_reg[g] <= ~line_reg[g];
                    bit_cnt_reg[g] <= (bit_cnt_reg[g] == 6'd31) ? 6'h0 : bit_cnt_reg[g] + 6'h1;
                    if (take)
                        shift_reg[g] <= (mode == PIN_LIVE && bd_valid[g])
                                        ? bd_data[g].sample[WORD_BITS-1:0] : '0;
                    else
                        shift_reg[g] <= {shift_reg[g][WORD_BITS-2:0], 1'b0};
                end
                else if (shift_reg[g][WORD_BITS-1] && bit_cnt_reg[g] >= 6'd4)
                    line_reg[g] <= ~line_reg[g];
            end
            else
            begin
                bit_cnt_reg[g] <= 6'h0;
                cell_reg[g] <= 1'b0;
                line_reg[g] <= 1'b0;
            end
        end
    end

    // Ready back to the link follows buffer room on both lanes
    assign pri_ready_o = bd_room[0];
    assign sec_ready_o = bd_room[1];

    // Primary pin drivers; reset releases the pin and turns its pull-down on
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            primary_digital_out_pin_o <= 1'b0;
            primary_digital_out_pin_oe_o <= 1'b0;
            primary_pulldown_o <= 1'b1;
        end
        else
        begin
            primary_digital_out_pin_oe_o <= (pri_mode != PIN_HIZ);
            primary_pulldown_o <= (pri_mode == PIN_HIZ);
            primary_digital_out_pin_o <= (pri_mode == PIN_ZERO || pri_mode == PIN_HIZ)
                                         ? 1'b0 : line_reg[0];
        end
    end

    // Secondary pin drivers, including the general I/O takeover
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            secondary_digital_out_pin_o <= 1'b0;
            secondary_digital_out_pin_oe_o <= 1'b0;
            secondary_pulldown_o <= 1'b1;
            secondary_pullup_o <= 1'b0;
        end
        else if (sec_mode == PIN_GPIO)
        begin
            secondary_digital_out_pin_o <= gpio_out_i;
            secondary_digital_out_pin_oe_o <= gpio_dir_out_i;
            secondary_pulldown_o <= 1'b0;
            secondary_pullup_o <= 1'b1;
        end
        else
        begin
            secondary_digital_out_pin_oe_o <= (sec_mode != PIN_HIZ);
            // Pull-down stays on while driving in D0 only
            secondary_pulldown_o <= (sec_mode == PIN_HIZ) || (pwr_reg == PWR_D0);
            secondary_pullup_o <= 1'b0;
            secondary_digital_out_pin_o <= (sec_mode == PIN_ZERO || sec_mode == PIN_HIZ)
                                           ? 1'b0 : line_reg[1];
        end
    end

    // Three-stage synchronisers for asynchronous pins
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            in_sync_reg <= '0;
            gp_sync_reg <= '0;
            jack_sync_reg <= '1; // Jack idles high, so no false plug after reset
        end
        else
        begin
            in_sync_reg <= {in_sync_reg[SYNC_STAGES-2:0], spdif_in_pin_i};
            gp_sync_reg <= {gp_sync_reg[SYNC_STAGES-2:0], secondary_digital_out_pin_o};
            jack_sync_reg <= {jack_sync_reg[SYNC_STAGES-2:0], in_jack_sense_i};
        end
    end

    // Level change on the last stage; a two-sample filter would eat the
    // one-cell pulses of the top input rates, which last under two clocks
    assign in_change = (in_sync_reg[2] != in_level_reg);

    // Rate tracker: clocks spanned by one subframe's worth of level changes
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            in_level_reg <= 1'b0;
            gap_cnt_reg <= 8'h0;
            span_cnt_reg <= 8'hff;
            win_cnt_reg <= 8'h0;
            in_rate_reg <= RATE_NONE;
        end
        else if (pwr_reg != PWR_D0)
        begin
            in_rate_reg <= RATE_NONE;
            span_cnt_reg <= 8'hff;
            win_cnt_reg <= 8'h0;
            gap_cnt_reg <= 8'h0;
        end
        else if (in_change && win_cnt_reg == 8'(RATE_WIN_EDGES - 1))
        begin
            in_level_reg <= in_sync_reg[2];
            gap_cnt_reg <= 8'h0;
            in_rate_reg <= rate_bin(span_cnt_reg);
            win_cnt_reg <= 8'h0;
            span_cnt_reg <= 8'h1;
        end
        else
        begin
            // Span saturates, so a window that spans idle time bins as none
            if (span_cnt_reg != 8'hff)
                span_cnt_reg <= span_cnt_reg + 8'h1;
            if (in_change)
            begin
                in_level_reg <= in_sync_reg[2];
                gap_cnt_reg <= 8'h0;
                win_cnt_reg <= win_cnt_reg + 8'h1;
            end
            else if (gap_cnt_reg != 8'hff)
                gap_cnt_reg <= gap_cnt_reg + 8'h1;
            else
                in_rate_reg <= RATE_NONE;
        end
    end

    // Input status and routing
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            in_jack_present_o <= 1'b0;
            in_to_record_o <= 1'b0;
            in_to_play_o <= 1'b0;
            in_rate_o <= RATE_NONE;
            gpio_in_o <= 1'b0;
            pwr_state_o <= 2'h3;
        end
        else
        begin
            in_jack_present_o <= ~jack_sync_reg[2];
            in_to_record_o <= in_record_sel_i && (pwr_reg == PWR_D0);
            in_to_play_o <= in_play_route_i && (pwr_reg == PWR_D0);
            in_rate_o <= in_rate_reg;
            gpio_in_o <= gp_sync_reg[2];
            pwr_state_o <= pwr_reg;
        end
    end
endmodule

// ### testbench/dsp_chk.sv
// Assertions for the digital audio pin control block.
// Bound to dsp_top; sees only its ports, one clock domain.
module dsp_chk
    import dsp_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    // Controls
    input wire logic pwr_set_i,
    input wire dsp_pkg::dsp_pwr_type pwr_value_i,
    input wire dsp_pkg::dsp_cnv_ctl_type primary_out_converter_i,
    input wire dsp_pkg::dsp_cnv_ctl_type secondary_out_converter_i,
    input wire logic shared_general_io_function_en_i,
    input wire logic gpio_out_i,
    input wire logic gpio_dir_out_i,
    // Pins and status
    input wire logic primary_digital_out_pin_o,
    input wire logic primary_digital_out_pin_oe_o,
    input wire logic primary_pulldown_o,
    input wire logic secondary_digital_out_pin_o,
    input wire logic secondary_digital_out_pin_oe_o,
    input wire logic secondary_pulldown_o,
    input wire logic secondary_pullup_o,
    input wire dsp_pkg::dsp_rate_type in_rate_o,
    input wire logic [1:0] pwr_state_o
);
    dsp_cnv_ctl_type pc, sc;
    logic p_oe, p_pd, s_oe, s_pd, gpe, d0, d12, framing, last_reg;
    logic [3:0] still_reg;
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);
    // Short names for the watched ports
    assign pc = primary_out_converter_i;
    assign sc = secondary_out_converter_i;
    assign p_oe = primary_digital_out_pin_oe_o;
    assign p_pd = primary_pulldown_o;
    assign s_oe = secondary_digital_out_pin_oe_o;
    assign s_pd = secondary_pulldown_o;
    assign gpe = shared_general_io_function_en_i;
    assign d0 = pwr_state_o == 2'h0;
    assign d12 = pwr_state_o == 2'h1 || pwr_state_o == 2'h2;
    assign framing = p_oe && d0 && pc.out_enable && pc.dig_enable;
    // Run of an unchanged primary level; biphase never rests more than three cells
    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            still_reg <= 4'h0;
            last_reg <= 1'b0;
        end
        else
        begin
            last_reg <= primary_digital_out_pin_o;
            if (!framing || primary_digital_out_pin_o != last_reg)
                still_reg <= 4'h0;
            else if (still_reg != 4'hf)
                still_reg <= still_reg + 4'h1;
        end
    end
    rst_exit_a: assert property ($rose(reset_n_i) |-> !p_oe && p_pd && pwr_state_o == 2'h3)
        else $error("pins not floating at reset exit");
    d3_float_a: assert property (pwr_state_o == 2'h3 [*2] |-> !p_oe && p_pd)
        else $error("primary pin driven in D3");
    oe_off_a: assert property (!$past(pc.out_enable) |-> !p_oe && p_pd)
        else $error("primary pin driven while disabled");
    drive_zero_a: assert property ($past(pc.out_enable) && (d12 || d0 && !$past(pc.dig_enable))
        |-> p_oe && !primary_digital_out_pin_o && !p_pd)
        else $error("primary pin not driving zero");
    live_drive_a: assert property (d0 && $past(pc.out_enable && pc.dig_enable) |-> p_oe && !p_pd)
        else $error("primary pin not driving live");
    sec_pull_a: assert property (d0 && $past(!gpe && sc.out_enable) |-> s_oe && s_pd)
        else $error("secondary pull-down lost in D0");
    sec_zero_a: assert property (d12 && $past(!gpe && sc.out_enable)
        |-> s_oe && !secondary_digital_out_pin_o && !s_pd)
        else $error("secondary pin not driving zero");
    gpio_follow_a: assert property ($past(gpe) |-> secondary_pullup_o
        && s_oe == $past(gpio_dir_out_i) && (!s_oe || secondary_digital_out_pin_o == $past(gpio_out_i)))
        else $error("secondary pin not following general I/O");
    pwr_load_a: assert property (pwr_set_i |-> ##2 pwr_state_o == $past(pwr_value_i, 2))
        else $error("power state not loaded");
    framing_a: assert property (still_reg < 4'h8)
        else $error("framing stalled on primary pin");
    rate_idle_a: assert property (!d0 [*2] |-> in_rate_o == RATE_NONE)
        else $error("input rate reported outside D0");
    live_c: cover property (framing && pc.stream_id != 4'h0);
    gpio_c: cover property (gpe && s_oe);
    low_pwr_c: cover property (d12 && p_oe);
endmodule

// ### testbench/dsp_far_end.sv
// Far side: gear receiving the primary output, and a transmitter
// feeding the digital input. Behavioural, timed in ns.
module dsp_far_end
(
    // Primary output pin as the block drives it
    input wire logic pin_i,
    input wire logic oe_i,
    input wire logic pulldown_i,
    // Transmitter control from the bench
    input wire logic send_i,
    input wire logic [15:0] cell_ns_i,
    // Line seen by the receiver, and the transmitted line
    output logic line_o,
    output logic spdif_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released line falls to the pull-down; without one, stale reads are exposed
    assign line_o = oe_i ? pin_i : (pulldown_i ? 1'b0 : ~pin_i);
    // Biphase frames, two 64-cell subframes; line stands still while idle
    initial
    begin
        spdif_o = 1'b0;
        forever
        begin
            wait (send_i);
            for (int s = 0; s < 2; s++)
            begin
                for (int p = 0; p < 4; p++)
                begin
                    spdif_o = ~spdif_o;
                    #(cell_ns_i * ((p == 0 || p == 3) ? 3 : 1));
                end
                for (int b = 0; b < 28; b++)
                begin
                    spdif_o = ~spdif_o;
                    #(cell_ns_i);
                    if (b[0])
                        spdif_o = ~spdif_o;
                    #(cell_ns_i);
                end
            end
        end
    end
endmodule

// ### testbench/tb.sv
// Testbench for the digital audio pin control block.
// Inputs change 5 ns after each rising edge; dsp_far_end is the far side.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dsp_pkg::*;
    logic clk_sys_i, reset_n_i, pwr_set_i, shared_general_io_function_en_i, gpio_out_i;
    logic gpio_dir_out_i, pri_valid_i, pri_ready_o, sec_valid_i, sec_ready_o, gpio_in_o;
    logic primary_digital_out_pin_o, primary_digital_out_pin_oe_o, primary_pulldown_o;
    logic secondary_digital_out_pin_o, secondary_digital_out_pin_oe_o, secondary_pulldown_o;
    logic secondary_pullup_o, spdif_in_pin_i, in_jack_sense_i, in_record_sel_i;
    logic in_play_route_i, in_jack_present_o, in_to_record_o, in_to_play_o, p_line, src_send;
    logic [1:0] pwr_state_o;
    logic [15:0] src_cell;
    dsp_pwr_type pwr_value_i;
    dsp_cnv_ctl_type primary_out_converter_i, secondary_out_converter_i;
    dsp_word_type pri_data_i, sec_data_i;
    dsp_rate_type in_rate_o, rate_sel;
    int err_count, total_checks, n;
    // {out, dig, stream id, expected oe, primary pd, secondary pd, moving}
    localparam logic [9:0] D0_TAB [5] = '{10'h006, 10'h20a, 10'h30b, 10'h31b, 10'h3fb};
    localparam int RATE_HZ [4] = '{44100, 48000, 88200, 96000};
    dsp_top dut (.*);
    dsp_far_end far (.pin_i(primary_digital_out_pin_o), .oe_i(primary_digital_out_pin_oe_o),
        .pulldown_i(primary_pulldown_o), .send_i(src_send), .cell_ns_i(src_cell),
        .line_o(p_line), .spdif_o(spdif_in_pin_i));
    // Free-running system clock, 50 ns
    initial
    begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    task automatic tick(input int c);
        repeat (c) @(posedge clk_sys_i);
        #5;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic pwr(input dsp_pwr_type v);
        pwr_value_i = v;
        pwr_set_i = 1'b1;
        tick(1);
        pwr_set_i = 1'b0;
        tick(3);
    endtask
    // Both converters get the same controls so the two pins can be compared
    task automatic cnv(input logic o, input logic d, input logic [3:0] id);
        primary_out_converter_i = '{o, d, id, rate_sel, 5'h18};
        secondary_out_converter_i = primary_out_converter_i;
        tick(2);
    endtask
    // Framing must keep moving; a released or zeroed line must sit low
    task automatic pins(input logic [3:0] e);
        int ep, es;
        logic lp, ls;
        ep = 0;
        es = 0;
        check(primary_digital_out_pin_oe_o, e[3]);
        check(secondary_digital_out_pin_oe_o, e[3]);
        check(primary_pulldown_o, e[2]);
        check(secondary_pulldown_o, e[1]);
        repeat (40)
        begin
            lp = p_line;
            ls = secondary_digital_out_pin_o;
            tick(1);
            ep += int'(p_line != lp);
            es += int'(secondary_digital_out_pin_o != ls);
        end
        check(ep > 8, e[0]);
        check(es > 8, e[0]);
        if (!e[0])
            check(p_line, 1'b0);
    endtask
    // Watchdog, well past the expected run of about 4400 cycles
    initial
    begin
        #1000000;
        err_count++;
        stop_test();
    end
    initial
    begin
        {reset_n_i, pwr_set_i, shared_general_io_function_en_i, gpio_out_i} = 4'h0;
        {gpio_dir_out_i, pri_valid_i, sec_valid_i, in_record_sel_i} = 4'h0;
        {in_play_route_i, src_send} = 2'h0;
        in_jack_sense_i = 1'b1;
        src_cell = 16'h00a3;
        pwr_value_i = PWR_D3;
        rate_sel = RATE_48K;
        primary_out_converter_i = '0;
        secondary_out_converter_i = '0;
        pri_data_i = '{24'habcdef, 1'b0};
        sec_data_i = '{24'h123456, 1'b1};
        tick(10);
        reset_n_i = 1'b1;
        tick(1);
        check(pwr_state_o, 2'h3);
        check(in_rate_o, RATE_NONE);
        check(secondary_pullup_o, 1'b0);
        cnv(1'b1, 1'b1, 4'h5);
        pins(4'h6);
        n = 0;
        pri_valid_i = 1'b1;
        sec_valid_i = 1'b1;
        repeat (5)
        begin
            n += int'(pri_ready_o);
            tick(1);
        end
        check(n, 2);
        check(sec_ready_o, 1'b0);
        $display("test reset and D3 done");
        pwr(PWR_D0);
        n = 0;
        while (!pri_ready_o && n < 300)
        begin
            tick(1);
            n++;
        end
        check(pri_ready_o, 1'b1);
        pri_valid_i = 1'b0;
        sec_valid_i = 1'b0;
        for (int i = 0; i < 5; i++)
            begin
            cnv(D0_TAB[i][9], D0_TAB[i][8], D0_TAB[i][7:4]);
            pins(D0_TAB[i][3:0]);
        end
        for (int r = 0; r < 6; r++)
        begin
            rate_sel = dsp_rate_type'(r);
            cnv(1'b1, 1'b1, 4'h3);
            pins(4'hb);
        end
        $display("test D0 decode done");
        for (int v = 1; v < 3; v++)
        begin
            pwr(dsp_pwr_type'(v));
            cnv(1'b1, 1'b1, 4'h9);
            pins(4'h8);
            cnv(1'b0, 1'b0, 4'h0);
            pins(4'h6);
        end
        {shared_general_io_function_en_i, gpio_dir_out_i} = 2'h3;
        for (int g = 0; g < 2; g++)
        begin
            gpio_out_i = g[0];
            tick(5);
            check(secondary_digital_out_pin_o, g[0]);
            check(gpio_in_o, g[0]);
            check({secondary_digital_out_pin_oe_o, secondary_pullup_o}, 2'h3);
        end
        gpio_dir_out_i = 1'b0;
        tick(2);
        check(secondary_digital_out_pin_oe_o, 1'b0);
        shared_general_io_function_en_i = 1'b0;
        $display("test low power and general I/O done");
        pwr(PWR_D0);
        {in_jack_sense_i, in_record_sel_i, in_play_route_i} = 3'h3;
        tick(8);
        check({in_jack_present_o, in_to_record_o, in_to_play_o}, 3'h7);
        for (int i = 0; i < 4; i++)
        begin
            src_cell = 16'(1000000000 / (RATE_HZ[i] * 128));
            src_send = 1'b1;
            tick(600);
            check(in_rate_o, dsp_rate_type'(i));
            src_send = 1'b0;
            tick(300);
        end
        in_jack_sense_i = 1'b1;
        pwr(PWR_D3);
        tick(4);
        check({in_jack_present_o, in_rate_o}, {1'b0, RATE_NONE});
        $display("test digital input done");
        pwr(PWR_D0);
        cnv(1'b1, 1'b1, 4'h5);
        reset_n_i = 1'b0;
        tick(3);
        check({primary_digital_out_pin_oe_o, primary_pulldown_o}, 2'h1);
        reset_n_i = 1'b1;
        tick(1);
        check(pwr_state_o, 2'h3);
        $display("test reset in flight done");
        stop_test();
    end
endmodule
bind dsp_top dsp_chk u_chk (.*);
